//--- core/acrpc_config_regs.v
// configuration bank: clock input modes, rail quieting, full-scale range, power mode, edge position status
// assumes a byte-wide register access port (address, write strobe, data) on clk; the analog side is outside
`timescale 1ns/100ps
`include "acrpc_defines.vh"

// Summary of operation
// - clock mode bit 2 selects PECL for device clock, disables self-bias
// - clock mode bit 1 selects PECL for SYSREF, disables self-bias
// - clock mode bit 0 inverts SYSREF before alignment; reset no inversion
// - noise register bit 2 quiets analog clock rail; bit 2 resets zero, register resets 0x10
// - noise register bit 0 quiets clock core rail; bit 1 reserved
// - report 24-bit SYSREF edge position relative to device clock
// - 16-bit full-scale code sets range of all channels; reset 0xA000
// - power mode code 0x46 low power, 0x4B high performance; others invalid
module acrpc_config_regs (
   input wire clk,                       // configuration interface clock
   input wire sys_rst,                   // asynchronous reset, active high
   input wire [7:0] regAddr,             // register offset
   input wire regWrite,                  // write strobe, one cycle
   input wire [7:0] regWdata,            // write data byte
   input wire regRead,                   // read strobe, one cycle
   input wire [2:0] regByteSel,          // byte lane for multi-byte registers, 0 = lsb
   output reg [7:0] regRdata,            // read data, valid cycle after regRead
   input wire [23:0] sysrefEdgeIn,       // edge position from the detector, other domain
   input wire sysrefIn,                  // raw SYSREF level from the input buffer
   output wire sysrefAligned,            // SYSREF after optional polarity flip
   output wire devicePeclSelect,         // device clock input in PECL mode
   output wire sysrefPeclSelect,         // SYSREF input in PECL mode
   output wire analogRailQuiet,          // analog clock rail noise suppression
   output wire coreRailQuiet,            // clock core rail noise suppression
   output wire [15:0] fullScaleCode,     // full-scale range code for all channels
   output wire lowPowerMode,             // low power mode selected
   output wire powerModeValid            // power mode code is one of the two legal values
);

   reg [7:0] clkMode_q;
   reg [7:0] noise_q;
   reg [15:0] fsr_q;
   reg [7:0] pmode_q;
   reg [23:0] edgeS1_q;
   reg [23:0] edgeS2_q;
   reg [23:0] edgeS3_q;
   reg [23:0] edge_q;
   reg [7:0] rdata_d;
   wire [7:0] fsrByte;
   wire [7:0] edgeByte;

   // writable registers; reserved bits are stored as written, software keeps them at default
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         clkMode_q <= `ACRPC_RST_CLKMODE;
         noise_q <= `ACRPC_RST_NOISE;
         fsr_q <= `ACRPC_RST_FSR;
         pmode_q <= `ACRPC_RST_PMODE;
      end else if (regWrite) begin
         case (regAddr)
            `ACRPC_OFS_CLKMODE: clkMode_q <= regWdata;
            `ACRPC_OFS_NOISE: noise_q <= regWdata;
            `ACRPC_OFS_FSR: begin
               if (regByteSel == 3'h0)
                  fsr_q[7:0] <= regWdata;
               else if (regByteSel == 3'h1)
                  fsr_q[15:8] <= regWdata;
            end
            `ACRPC_OFS_PMODE: pmode_q <= regWdata;
            default: ;
         endcase
      end
   end

   // edge status crosses from the detector; three stages, accept only when stages two and three agree
   // limitation: a word changing every cycle may never settle, the detector holds it steady
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         edgeS1_q <= `ACRPC_RST_EDGE;
         edgeS2_q <= `ACRPC_RST_EDGE;
         edgeS3_q <= `ACRPC_RST_EDGE;
         edge_q <= `ACRPC_RST_EDGE;
      end else begin
         edgeS1_q <= sysrefEdgeIn;
         edgeS2_q <= edgeS1_q;
         edgeS3_q <= edgeS2_q;
         if (edgeS2_q == edgeS3_q)
            edge_q <= edgeS3_q;
      end
   end

   assign fsrByte = (regByteSel == 3'h0) ? fsr_q[7:0] : (regByteSel == 3'h1) ? fsr_q[15:8] : 8'h00;
   assign edgeByte = (regByteSel == 3'h0) ? edge_q[7:0] : (regByteSel == 3'h1) ? edge_q[15:8] :
                     (regByteSel == 3'h2) ? edge_q[23:16] : 8'h00;

   // read mux; unmapped offsets read zero
   always @* begin
      case (regAddr)
         `ACRPC_OFS_CLKMODE: rdata_d = clkMode_q;
         `ACRPC_OFS_NOISE: rdata_d = noise_q;
         `ACRPC_OFS_EDGE: rdata_d = edgeByte;
         `ACRPC_OFS_FSR: rdata_d = fsrByte;
         `ACRPC_OFS_PMODE: rdata_d = pmode_q;
         default: rdata_d = 8'h00;
      endcase
   end

   // registered read data holds until the next read
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         regRdata <= 8'h00;
      else if (regRead)
         regRdata <= rdata_d;
   end

   // controls to the analog side
   assign devicePeclSelect = clkMode_q[`ACRPC_BIT_DEVPECL];
   assign sysrefPeclSelect = clkMode_q[`ACRPC_BIT_SRPECL];
   assign sysrefAligned = sysrefIn ^ clkMode_q[`ACRPC_BIT_SRFLIP];
   assign analogRailQuiet = noise_q[`ACRPC_BIT_ANAQUIET];
   assign coreRailQuiet = noise_q[`ACRPC_BIT_CORQUIET];
   assign fullScaleCode = fsr_q;
   assign lowPowerMode = (pmode_q == `ACRPC_PMODE_LOW);
   assign powerModeValid = (pmode_q == `ACRPC_PMODE_LOW) || (pmode_q == `ACRPC_PMODE_HIGH);

endmodule

//--- core/acrpc_defines.vh
// register offsets, reset values and field positions of the clock, range and power configuration bank
// assumes byte-wide register access at the printed offsets
`ifndef ACRPC_DEFINES_VH
`define ACRPC_DEFINES_VH
`define ACRPC_ADDR_W 8
`define ACRPC_OFS_CLKMODE 8'h2A
`define ACRPC_OFS_NOISE 8'h2B
`define ACRPC_OFS_EDGE 8'h2C
`define ACRPC_OFS_FSR 8'h30
`define ACRPC_OFS_PMODE 8'h37
`define ACRPC_RST_CLKMODE 8'h00
`define ACRPC_RST_NOISE 8'h10
`define ACRPC_RST_EDGE 24'h000000
`define ACRPC_RST_FSR 16'hA000
`define ACRPC_RST_PMODE 8'h4B
`define ACRPC_BIT_DEVPECL 2
`define ACRPC_BIT_SRPECL 1
`define ACRPC_BIT_SRFLIP 0
`define ACRPC_BIT_ANAQUIET 2
`define ACRPC_BIT_CORQUIET 0
`define ACRPC_PMODE_LOW 8'h46
`define ACRPC_PMODE_HIGH 8'h4B
`define ACRPC_FSR_MIN 16'h2000
`endif

//--- testbench/acrpc_regs_props.sv
// checker: output relations of the clock, range and power configuration bank
// assumes a bind to acrpc_config_regs by port name
`timescale 1ns/100ps
module acrpc_regs_props (input wire clk, sys_rst, regWrite, regRead, sysrefIn, sysrefAligned, devicePeclSelect,
   sysrefPeclSelect, analogRailQuiet, coreRailQuiet, lowPowerMode, powerModeValid,
   input wire [7:0] regAddr, regWdata, input wire [2:0] regByteSel, input wire [15:0] fullScaleCode);
   // single-byte registers take a write on any lane; these checks cover lane zero writes, except a_fsr_high (lane one range write) and a_hold_idle (no write)
   wire w0 = regWrite && regByteSel == 3'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_flip_write: assert property (w0 && regAddr == 8'h2A |=>
      sysrefAligned == (sysrefIn ^ $past(regWdata[0]))) else $error("polarity flip wrong");
   a_pecl_write: assert property (w0 && regAddr == 8'h2A |=>
      {devicePeclSelect, sysrefPeclSelect} == $past(regWdata[2:1])) else $error("pecl select wrong");
   a_quiet_write: assert property (w0 && regAddr == 8'h2B |=>
      {analogRailQuiet, coreRailQuiet} == {$past(regWdata[2]), $past(regWdata[0])}) else $error("quiet wrong");
   a_fsr_low: assert property (w0 && regAddr == 8'h30 |=>
      fullScaleCode[7:0] == $past(regWdata)) else $error("range low byte wrong");
   a_fsr_high: assert property (regWrite && regAddr == 8'h30 && regByteSel == 3'h1 |=>
      fullScaleCode == {$past(regWdata), $past(fullScaleCode[7:0])}) else $error("range high byte wrong");
   a_low_decode: assert property (w0 && regAddr == 8'h37 |=>
      lowPowerMode == ($past(regWdata) == 8'h46)) else $error("low power decode wrong");
   a_valid_decode: assert property (w0 && regAddr == 8'h37 |=>
      powerModeValid == ($past(regWdata) inside {8'h46, 8'h4B})) else $error("mode valid wrong");
   a_hold_idle: assert property (!regWrite |=>
      $stable({fullScaleCode, lowPowerMode, devicePeclSelect, coreRailQuiet})) else $error("output moved");
   cover property (w0 && regAddr == 8'h37 && regWdata == 8'h46);
   cover property (regRead && regAddr == 8'h2C);
   cover property (w0 && regAddr == 8'h2A && regWdata[0]);
endmodule

//--- testbench/tb_top.sv
// testbench: readback table, decode outputs, status field, reset values
// assumes acrpc_config_regs and acrpc_regs_props compiled alongside
`timescale 1ns/100ps
module tb_top;
   logic clk = 1'h0, sys_rst = 1'h1, regWrite = 1'h0, regRead = 1'h0, sysrefIn = 1'h0;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00;
   logic [2:0] regByteSel = 3'h0;
   logic [23:0] sysrefEdgeIn = 24'h5A3C81;
   wire [7:0] regRdata;
   wire [15:0] fullScaleCode;
   wire sysrefAligned, devicePeclSelect, sysrefPeclSelect, analogRailQuiet, coreRailQuiet, lowPowerMode, powerModeValid;
   int num_errors = 0, compares = 0;
   // rows: offset, lane, byte written, readback; reserved bits keep defaults
   logic [26:0] rows [8] = '{{8'h2A, 3'h0, 8'h05, 8'h05}, {8'h2A, 3'h0, 8'h02, 8'h02}, {8'h2B, 3'h0, 8'h15, 8'h15},
      {8'h2B, 3'h0, 8'h10, 8'h10}, {8'h30, 3'h0, 8'h34, 8'h34}, {8'h30, 3'h1, 8'h32, 8'h32},
      {8'h37, 3'h0, 8'h46, 8'h46}, {8'h37, 3'h0, 8'h4B, 8'h4B}};
   acrpc_config_regs i_dut (.*);
   initial forever #25 clk = ~clk;
   task chk(input logic [23:0] got, exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // strobes are swapped at entry so no signal is assigned twice in one step
   task wr(input logic [7:0] a, input logic [2:0] s, input logic [7:0] d);
      regAddr = a; regByteSel = s; regWdata = d; regRead = 1'h0; regWrite = 1'h1;
      @(posedge clk) #5;
   endtask
   task rd(input logic [7:0] a, input logic [2:0] s, input logic [7:0] e);
      regAddr = a; regByteSel = s; regWrite = 1'h0; regRead = 1'h1;
      @(posedge clk) #5;
      chk(regRdata, e);
   endtask
   task reset_dut;
      regWrite = 1'h0; regRead = 1'h0; sys_rst = 1'h1;
      repeat (3) @(posedge clk);
      #5 sys_rst = 1'h0;
   endtask
   task stop_test;
      if (num_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // watchdog: the whole sequence needs well under 100 cycles
   initial begin
      #20000;
      num_errors++;
      stop_test;
   end
   initial begin
      reset_dut;
      foreach (rows[i]) begin
         wr(rows[i][26:19], rows[i][18:16], rows[i][15:8]);
         rd(rows[i][26:19], rows[i][18:16], rows[i][7:0]);
      end
      chk(fullScaleCode, 16'h3234);
      chk({devicePeclSelect, sysrefPeclSelect, analogRailQuiet, coreRailQuiet}, 4'h4);
      wr(8'h2B, 3'h0, 8'h15);
      chk({analogRailQuiet, coreRailQuiet}, 2'h3);
      wr(8'h2A, 3'h0, 8'h01);
      sysrefIn = 1'h1;
      #1 chk(sysrefAligned, 1'h0);
      wr(8'h37, 3'h0, 8'h46);
      chk({lowPowerMode, powerModeValid}, 2'h3);
      rd(8'h2C, 3'h0, 8'h81);
      rd(8'h2C, 3'h1, 8'h3C);
      rd(8'h2C, 3'h2, 8'h5A);
      wr(8'h2C, 3'h0, 8'hFF);
      rd(8'h2C, 3'h0, 8'h81);
      rd(8'h2D, 3'h0, 8'h00);
      reset_dut;
      rd(8'h2A, 3'h0, 8'h00);
      rd(8'h2B, 3'h0, 8'h10);
      rd(8'h30, 3'h1, 8'hA0);
      rd(8'h37, 3'h0, 8'h4B);
      chk({lowPowerMode, powerModeValid, sysrefAligned}, 3'h3);
      stop_test;
   end
endmodule
bind acrpc_config_regs acrpc_regs_props i_chk (.*);
